// ---- logic/dcm_defs.svh ----
// constants for the dac control and mute logic
// Summary of operation
// - control-style pin low hardware, high software
// - mute pin low soft-mutes, high restores
// - floating mute pin outputs zero-detect state
// - zero output low while infinite zero
// - mute decays toward mid rail, 64 samples
// - mute release resumes from current sample
// - latch sets after 1024 zero samples
// - any non-zero sample clears the latch
// - mute pin high ignores latch unless enabled
// - format and wordlen pins select input format in hardware
// - source keeps frame sync 24 clocks each
// - exactly 32 clocks per frame forces 16-bit
// - data pin selects de-emphasis in hardware
// - 3-wire shifts data, latch pulse loads word
// - 16-bit word msb first, 7 address bits
// - host keeps wordlen pin low in 3-wire
// - software control defaults to 2-wire
// - 2-wire address final bit from strap
// - latch pin toggle forces permanent 3-wire; here a low control-style pin returns to 2-wire
// - interface register bit 8 enables zero detect
`ifndef DCM_DEFS_SVH
`define DCM_DEFS_SVH
`define DCM_WORD_BITS      5'd16
`define DCM_ADDR_MSB       15
`define DCM_ADDR_LSB       9
`define DCM_ADDR_IFACE     7'h03
`define DCM_ADDR_DAC       7'h02
`define DCM_IZD_BIT        8
`define DCM_MUTE_BIT       0
`define DCM_DEEMPH_BIT     1
`define DCM_ZERO_RUN       11'd1024
`define DCM_DECAY_SHIFT    6
`define DCM_FRAME_16       6'd32
`define DCM_BUS_ADDR_HI    6'h2a  // upper six bus address bits; value is arbitrary
`endif

// ---- logic/dcm_pkg.sv ----
// types used by the dac end of the control link and by the bench
package dcm_pkg;
  typedef enum logic [1:0] {
    DCM_FMT_RJ24  = 2'b00,
    DCM_FMT_RJ20  = 2'b01,
    DCM_FMT_I2S16 = 2'b10,
    DCM_FMT_I2S24 = 2'b11
  } dcm_fmt_type;
  typedef enum logic [2:0] {
    DCM_TW_IDLE = 3'b000,
    DCM_TW_ADDR = 3'b001,
    DCM_TW_ACK  = 3'b010,
    DCM_TW_DATA = 3'b011,
    DCM_TW_SKIP = 3'b100
  } dcm_tw_type;
endpackage

// ---- logic/dcm_link_if.sv ----
// link wires between host and dac control logic
`timescale 1ns/1ps
interface dcm_link_if;
  logic ctl_clk;       // serial control clock, made by host
  logic mode_sel;      // control style
  logic data_o_host;   // host drive of serial data pin
  logic data_oe_n_host;
  logic data_o_dev;    // device drive (ack)
  logic data_oe_n_dev;
  logic data_pin;      // resolved open-drain level
  logic latch_pin;     // latch_format_pin
  logic wordlen_pin;   // select_wordlen_pin
  assign data_pin = (!data_oe_n_host && !data_o_host) ||
                    (!data_oe_n_dev && !data_o_dev) ? 1'b0 : 1'b1;
  modport host (output ctl_clk, mode_sel, data_o_host, data_oe_n_host,
                latch_pin, wordlen_pin, input data_pin);
  modport dev (input ctl_clk, mode_sel, data_pin, latch_pin, wordlen_pin,
               output data_o_dev, data_oe_n_dev);
endinterface

// ---- logic/dcm_dev.sv ----
// dac control end: serial control port, hardware straps and mute logic
`timescale 1ns/1ps
`include "dcm_defs.svh"
module dcm_dev #(
  parameter int SAMPLE_W = 24  // audio sample width
) (
  // master clock domain
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  // link side
  dcm_link_if.dev                  lnk,
  // audio sample stream (clk_sys)
  input  wire logic                smp_valid,
  input  wire logic [SAMPLE_W-1:0] smp_left,
  input  wire logic [SAMPLE_W-1:0] smp_right,
  input  wire logic                bit_clock_in,
  input  wire logic                frame_sync_in,
  // mute pin as four signals
  input  wire logic                mute_n_in,
  input  wire logic                mute_n_driven,
  output logic                     mute_n_o,
  output logic                     mute_n_oe_n,
  // status and processed audio
  output logic                     zero_n_out,
  output logic                     auto_mute_latch_out,
  output logic [SAMPLE_W-1:0]      out_left,
  output logic [SAMPLE_W-1:0]      out_right,
  output dcm_pkg::dcm_fmt_type     fmt_sel,
  output logic                     force_16bit,
  output logic                     deemph_on,
  output logic                     soft_mute
);
  // ---------------- link clock domain ----------------
  logic [15:0] sh_reg;          // 3-wire shift register
  logic        three_wire_reg;  // sticky 3-wire selection
  logic        lat_seen_hi_reg; // latch pin went high in 2-wire
  logic        lat_d_reg;       // latch pin previous sample
  logic [15:0] word_reg;        // last completed word
  logic        word_tgl_reg;    // toggles per completed word
  logic        sda_d_reg;       // data pin previous sample for start detection
  dcm_pkg::dcm_tw_type tw_reg;  // 2-wire state
  logic [3:0]  bit_cnt_reg;
  logic [1:0]  byte_cnt_reg;
  logic        ack_reg;         // ack owed for the slot after this byte
  logic        ack_drv_reg;     // ack drive, moved to the falling edge
  logic [15:0] tw_sh_reg;       // 2-wire shift register
  logic        tw_done;         // last bit of the second data byte
  logic        addr_hit;        // address byte names this device

  // 3-wire shift and latch, msb first
  always_ff @(posedge lnk.ctl_clk or negedge nrst) begin
    if (!nrst) begin
      sh_reg    <= 16'h0000;
      lat_d_reg <= 1'b0;
    end else begin
      lat_d_reg <= lnk.latch_pin;
      if (three_wire_reg) sh_reg <= {sh_reg[14:0], lnk.data_pin};
    end
  end

  // permanent 3-wire entry after a low-high-low on latch pin;
  // control-style pin low (hardware) returns to 2-wire default
  always_ff @(posedge lnk.ctl_clk or negedge nrst) begin
    if (!nrst) begin
      three_wire_reg  <= 1'b0;
      lat_seen_hi_reg <= 1'b0;
    end else if (!lnk.mode_sel) begin
      three_wire_reg  <= 1'b0;
      lat_seen_hi_reg <= 1'b0;
    end else begin
      if (lnk.latch_pin && !lat_d_reg) lat_seen_hi_reg <= 1'b1;
      if (lat_seen_hi_reg && !lnk.latch_pin && lat_d_reg) three_wire_reg <= 1'b1;
    end
  end

  // 2-wire receiver; the data pin is sampled on ctl_clk so a start is seen as a
  // data edge between rising edges; stop is not decoded, idle follows the third ack slot -- limitation: host must
  // keep ctl_clk toggling around start/stop (host end does so)
  always_ff @(posedge lnk.ctl_clk or negedge nrst) begin
    if (!nrst) begin
      tw_reg       <= dcm_pkg::DCM_TW_IDLE;
      bit_cnt_reg  <= 4'h0;
      byte_cnt_reg <= 2'h0;
      ack_reg      <= 1'b0;
      sda_d_reg    <= 1'b1;
    end else begin
      sda_d_reg <= lnk.data_pin;
      case (tw_reg)
        dcm_pkg::DCM_TW_IDLE: begin
          ack_reg <= 1'b0;
          if (!three_wire_reg && lnk.mode_sel && sda_d_reg && !lnk.data_pin) begin
            tw_reg      <= dcm_pkg::DCM_TW_ADDR;  // start
            bit_cnt_reg <= 4'h0;
          end
        end
        dcm_pkg::DCM_TW_ADDR: begin
          bit_cnt_reg <= bit_cnt_reg + 4'd1;
          if (bit_cnt_reg == 4'd7) begin
            // a foreign address must never be acknowledged
            tw_reg       <= addr_hit ? dcm_pkg::DCM_TW_ACK : dcm_pkg::DCM_TW_SKIP;
            ack_reg      <= addr_hit;
            byte_cnt_reg <= 2'h0;
          end
        end
        dcm_pkg::DCM_TW_ACK: begin
          ack_reg     <= 1'b0;
          bit_cnt_reg <= 4'h0;
          if (byte_cnt_reg == 2'd2) tw_reg <= dcm_pkg::DCM_TW_IDLE; // stop
          else tw_reg <= dcm_pkg::DCM_TW_DATA;
        end
        dcm_pkg::DCM_TW_DATA: begin
          bit_cnt_reg <= bit_cnt_reg + 4'd1;
          if (bit_cnt_reg == 4'd7) begin
            tw_reg       <= dcm_pkg::DCM_TW_ACK;
            ack_reg      <= 1'b1;
            byte_cnt_reg <= byte_cnt_reg + 2'd1;
          end
        end
        dcm_pkg::DCM_TW_SKIP: begin
          ack_reg <= 1'b0;
          tw_reg  <= dcm_pkg::DCM_TW_IDLE;   // not our address, wait next start
        end
        default: tw_reg <= dcm_pkg::DCM_TW_IDLE;
      endcase
    end
  end

  // address compare; last bit comes from the strap level
  assign addr_hit = ({tw_sh_reg[6:0], lnk.data_pin} ==
                     {`DCM_BUS_ADDR_HI, lnk.wordlen_pin, 1'b0});

  // 2-wire shift register
  assign tw_done = (tw_reg == dcm_pkg::DCM_TW_DATA) && (bit_cnt_reg == 4'd7) &&
                   (byte_cnt_reg == 2'd1);
  always_ff @(posedge lnk.ctl_clk or negedge nrst) begin
    if (!nrst) tw_sh_reg <= 16'h0000;
    else if (tw_reg == dcm_pkg::DCM_TW_ADDR || tw_reg == dcm_pkg::DCM_TW_DATA)
      tw_sh_reg <= {tw_sh_reg[14:0], lnk.data_pin};
  end
  // ack drive starts at the falling edge after the eighth bit, so it never
  // overlaps the host's last bit and changes only while the clock is low
  always_ff @(negedge lnk.ctl_clk or negedge nrst) begin
    if (!nrst) ack_drv_reg <= 1'b0;
    else ack_drv_reg <= ack_reg;
  end

  // completed word from either style, announced by a toggle
  always_ff @(posedge lnk.ctl_clk or negedge nrst) begin
    if (!nrst) begin
      word_reg     <= 16'h0000;
      word_tgl_reg <= 1'b0;
    end else if (three_wire_reg && lnk.latch_pin && !lat_d_reg) begin
      word_reg     <= sh_reg;
      word_tgl_reg <= ~word_tgl_reg;
    end else if (tw_done) begin
      word_reg     <= {tw_sh_reg[14:0], lnk.data_pin};
      word_tgl_reg <= ~word_tgl_reg;
    end
  end

  // acknowledge by pulling the data pin low
  assign lnk.data_o_dev    = 1'b0;
  assign lnk.data_oe_n_dev = ~ack_drv_reg;

  // ---------------- master clock domain ----------------
  logic [2:0] tgl_sync_reg;   // word toggle crossing
  logic [1:0] mode_s_reg, lat_s_reg, wl_s_reg, dat_s_reg, mdrv_s_reg, min_s_reg;
  logic [1:0] bck_s_reg, lrc_s_reg;

  // two-stage synchronisers for every pin and the toggle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tgl_sync_reg <= 3'h0;
      mode_s_reg <= 2'h0;
      lat_s_reg  <= 2'h0;
      wl_s_reg   <= 2'h0;
      dat_s_reg  <= 2'h0;
      mdrv_s_reg <= 2'h0;
      min_s_reg  <= 2'h3;
      bck_s_reg  <= 2'h0;
      lrc_s_reg  <= 2'h0;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], word_tgl_reg};
      mode_s_reg <= {mode_s_reg[0], lnk.mode_sel};
      lat_s_reg  <= {lat_s_reg[0], lnk.latch_pin};
      wl_s_reg   <= {wl_s_reg[0], lnk.wordlen_pin};
      dat_s_reg  <= {dat_s_reg[0], lnk.data_pin};
      mdrv_s_reg <= {mdrv_s_reg[0], mute_n_driven};
      min_s_reg  <= {min_s_reg[0], mute_n_in};
      bck_s_reg  <= {bck_s_reg[0], bit_clock_in};
      lrc_s_reg  <= {lrc_s_reg[0], frame_sync_in};
    end
  end

  // control registers loaded from serial words; word_reg is stable
  // for many cycles after the toggle, so it is safe to sample here
  logic [8:0] dac_ctl_reg, if_ctl_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dac_ctl_reg <= 9'h000;
      if_ctl_reg  <= 9'h000;
    end else if (tgl_sync_reg[2] != tgl_sync_reg[1]) begin
      if (word_reg[`DCM_ADDR_MSB:`DCM_ADDR_LSB] == `DCM_ADDR_DAC) dac_ctl_reg <= word_reg[8:0];
      if (word_reg[`DCM_ADDR_MSB:`DCM_ADDR_LSB] == `DCM_ADDR_IFACE) if_ctl_reg <= word_reg[8:0];
    end
  end

  // hardware vs software selection of format and de-emphasis
  logic sw_mode;
  assign sw_mode = mode_s_reg[1];
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fmt_sel   <= dcm_pkg::DCM_FMT_RJ24;
      deemph_on <= 1'b0;
    end else if (!sw_mode) begin
      fmt_sel   <= dcm_pkg::dcm_fmt_type'({lat_s_reg[1], wl_s_reg[1]});
      deemph_on <= dat_s_reg[1];
    end else begin
      fmt_sel   <= dcm_pkg::DCM_FMT_RJ24;
      deemph_on <= dac_ctl_reg[`DCM_DEEMPH_BIT];
    end
  end

  // frame length detector: count bit clocks per frame-sync period
  logic       bck_d_reg, lrc_d_reg;
  logic [5:0] bck_cnt_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bck_d_reg   <= 1'b0;
      lrc_d_reg   <= 1'b0;
      bck_cnt_reg <= 6'h00;
      force_16bit <= 1'b0;
    end else begin
      bck_d_reg <= bck_s_reg[1];
      lrc_d_reg <= lrc_s_reg[1];
      if (lrc_s_reg[1] && !lrc_d_reg) begin
        force_16bit <= (bck_cnt_reg == `DCM_FRAME_16);
        bck_cnt_reg <= 6'h00;
      end else if (bck_s_reg[1] && !bck_d_reg && bck_cnt_reg != 6'h3f)
        bck_cnt_reg <= bck_cnt_reg + 6'd1;
    end
  end

  // automute: zero-run counter and latch
  logic [10:0] zrun_reg;
  logic        both_zero;
  assign both_zero = (smp_left == '0) && (smp_right == '0);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      zrun_reg            <= 11'h000;
      auto_mute_latch_out <= 1'b0;
    end else if (!if_ctl_reg[`DCM_IZD_BIT] && sw_mode) begin
      zrun_reg            <= 11'h000;
      auto_mute_latch_out <= 1'b0;
    end else if (smp_valid) begin
      if (!both_zero) begin
        zrun_reg            <= 11'h000;
        auto_mute_latch_out <= 1'b0;
      end else if (zrun_reg != `DCM_ZERO_RUN) begin
        zrun_reg <= zrun_reg + 11'd1;
        if (zrun_reg + 11'd1 == `DCM_ZERO_RUN) auto_mute_latch_out <= 1'b1;
      end
    end
  end

  // zero pin and mute pin drive
  assign zero_n_out  = ~auto_mute_latch_out;
  assign mute_n_o    = ~auto_mute_latch_out;
  assign mute_n_oe_n = mdrv_s_reg[1];          // released while driven outside

  // mute decision: driven pin low mutes, as does the latch if IZD bit set; undriven pin follows the latch; dac mute bit forces it in software
  logic mute_req;
  always_comb begin
    if (mdrv_s_reg[1])
      mute_req = !min_s_reg[1] ||
                 (if_ctl_reg[`DCM_IZD_BIT] && auto_mute_latch_out);
    else
      mute_req = auto_mute_latch_out;
    if (sw_mode && dac_ctl_reg[`DCM_MUTE_BIT]) mute_req = 1'b1;
  end
  assign soft_mute = mute_req;

  // soft mute: first-order decay toward mid rail (zero code), tau 64 samples
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      out_left  <= '0;
      out_right <= '0;
    end else if (smp_valid) begin
      if (mute_req) begin
        out_left  <= out_left  - SAMPLE_W'($signed(out_left)  >>> `DCM_DECAY_SHIFT);
        out_right <= out_right - SAMPLE_W'($signed(out_right) >>> `DCM_DECAY_SHIFT);
      end else begin
        out_left  <= smp_left;
        out_right <= smp_right;
      end
    end
  end
endmodule

// ---- logic/dcm_host.sv ----
// host end: generates the control clock and sends 2-wire or 3-wire words
`timescale 1ns/1ps
`include "dcm_defs.svh"
module dcm_host #(
  parameter int DIV = 4  // clk_sys cycles per half control clock
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // user request
  input  wire logic        req,
  input  wire logic [15:0] req_word,
  input  wire logic        use_3wire,
  input  wire logic        sw_mode,
  input  wire logic        strap_bit,
  output logic             busy,
  output logic             nack_seen,
  // link
  dcm_link_if.host         lnk
);
  logic [7:0]  div_reg;
  logic        sck_reg;
  logic [5:0]  step_reg;     // bit step within a transfer
  logic [26:0] frame_reg;    // bits still to send, msb first
  logic        run_reg, mode3_reg, lat_reg, sda_reg;
  logic        rise;

  // clock divider; the control clock runs free
  assign rise = (div_reg == 8'(DIV - 1)) && !sck_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 8'h00;
      sck_reg <= 1'b0;
    end else if (div_reg == 8'(DIV - 1)) begin
      div_reg <= 8'h00;
      sck_reg <= ~sck_reg;
    end else div_reg <= div_reg + 8'd1;
  end

  // transfer sequencer; data changes while sck is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      run_reg   <= 1'b0;
      mode3_reg <= 1'b0;
      step_reg  <= 6'h00;
      frame_reg <= '0;
      lat_reg   <= 1'b0;
      sda_reg   <= 1'b1;
      nack_seen <= 1'b0;
    end else if (!run_reg) begin
      lat_reg <= 1'b0;
      if (req) begin
        run_reg   <= 1'b1;
        mode3_reg <= use_3wire;
        step_reg  <= 6'h00;
        nack_seen <= 1'b0;
        // 2-wire: addr+w, ack slot, byte, ack slot, byte, ack slot
        frame_reg <= use_3wire ? {req_word, 11'h000} :
                     {`DCM_BUS_ADDR_HI, strap_bit, 1'b0, 1'b1, req_word[15:8], 1'b1,
                      req_word[7:0], 1'b1};
      end
    end else if (div_reg == 8'(DIV - 1) && sck_reg) begin
      // falling edge: set next bit
      step_reg <= step_reg + 6'd1;
      if (mode3_reg) begin
        if (step_reg < 6'd16) begin
          sda_reg   <= frame_reg[26];
          frame_reg <= {frame_reg[25:0], 1'b0};
        end else if (step_reg == 6'd16) lat_reg <= 1'b1;
        else begin
          lat_reg <= 1'b0;
          run_reg <= 1'b0;
        end
      end else begin
        if (step_reg == 6'd0) sda_reg <= 1'b0;  // start (data falls)
        else if (step_reg <= 6'd27) begin
          sda_reg   <= frame_reg[26];
          frame_reg <= {frame_reg[25:0], 1'b0};
        end else if (step_reg == 6'd28) sda_reg <= 1'b0;
        else begin
          sda_reg <= 1'b1;                      // stop (data rises)
          run_reg <= 1'b0;
        end
      end
    end else if (rise && !mode3_reg &&
                 (step_reg == 6'd10 || step_reg == 6'd19 || step_reg == 6'd28))
      nack_seen <= nack_seen | lnk.data_pin;    // device should pull low
  end

  assign busy               = run_reg;
  assign lnk.ctl_clk        = sck_reg;
  assign lnk.mode_sel       = sw_mode;
  assign lnk.data_o_host    = sda_reg;
  assign lnk.data_oe_n_host = sda_reg;           // open drain: release for high
  assign lnk.latch_pin      = lat_reg;
  assign lnk.wordlen_pin    = mode3_reg ? 1'b0 : strap_bit;
endmodule

// ---- verification/dcm_link_checker.sv ----
// concurrent checks on the control link between host and dac ends
`timescale 1ns/1ps
module dcm_link_checker (
  // clock and reset of the host side
  input wire logic clk_sys,
  input wire logic nrst,
  // link signals, sampled on clk_sys
  input wire logic ctl_clk,
  input wire logic mode_sel,
  input wire logic data_o_host,
  input wire logic data_oe_n_host,
  input wire logic data_o_dev,
  input wire logic data_oe_n_dev,
  input wire logic data_pin,
  input wire logic latch_pin,
  input wire logic wordlen_pin
);
  logic three_wire_reg;  // a latch pulse was seen since software mode began

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // mirror of the sticky 3-wire switch; only a mode drop clears it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      three_wire_reg <= 1'b0;
    end else if (!mode_sel) begin
      three_wire_reg <= 1'b0;
    end else if (latch_pin) begin
      three_wire_reg <= 1'b1;
    end
  end

  chk_ack_sw_only: assert property (!data_oe_n_dev |-> mode_sel)
    else $error("device drove the data pin in hardware mode");
  chk_ack_host_off: assert property (!data_oe_n_dev |-> data_oe_n_host)
    else $error("host and device drove the data pin together");
  chk_ack_one_bit: assert property ($fell(data_oe_n_dev) |-> ##[1:24] data_oe_n_dev)
    else $error("device acknowledge held too long");
  chk_ack_clk_low: assert property ($fell(data_oe_n_dev) |-> !ctl_clk)
    else $error("acknowledge started while control clock high");
  chk_latch_pulse: assert property ($rose(latch_pin) |-> ##[1:24] !latch_pin)
    else $error("latch pulse did not end");
  chk_wordlen_low_3w: assert property (latch_pin && mode_sel |-> !wordlen_pin)
    else $error("wordlen pin high during 3-wire latch");
  chk_no_ack_3w: assert property (three_wire_reg && mode_sel |-> data_oe_n_dev)
    else $error("device acknowledged after switching to 3-wire");
  chk_ack_wire_low: assert property (!data_oe_n_dev && !data_o_dev |-> !data_pin)
    else $error("acknowledge did not pull the data pin low");
endmodule

// ---- verification/tb_dac_control_and_mute_logic.sv ----
// self-checking bench: host and dac ends joined over the control link
`timescale 1ns/1ps
`include "dcm_defs.svh"
module tb_dac_control_and_mute_logic;
  logic                 clk_sys, nrst, req, use_3wire, sw_mode, strap_bit;
  logic [15:0]          req_word;
  logic                 smp_valid, bit_clock_in, frame_sync_in;
  logic [23:0]          smp_left, smp_right, out_left, out_right;
  logic                 mute_drv, mute_n_driven;  // bench drive of the mute pin
  logic                 busy, nack_seen, mute_n_o, mute_n_oe_n, zero_n_out;
  logic                 auto_mute_latch_out, force_16bit, deemph_on, soft_mute;
  dcm_pkg::dcm_fmt_type fmt_sel;
  int                   fail_count, comparisons, cycles;
  localparam logic [23:0] V = 24'h400000;  // steady test level
  // pin level: bench drive, else device drive, else the weak pull-up
  wire mute_n_in = mute_n_driven ? mute_drv : (mute_n_oe_n ? 1'b1 : mute_n_o);

  dcm_link_if lnk ();
  dcm_host #(.DIV(4)) dcm_host_inst (.clk_sys, .nrst, .req, .req_word, .use_3wire,
    .sw_mode, .strap_bit, .busy, .nack_seen, .lnk(lnk));
  dcm_dev #(.SAMPLE_W(24)) dcm_dev_inst (.clk_sys, .nrst, .lnk(lnk), .smp_valid,
    .smp_left, .smp_right, .bit_clock_in, .frame_sync_in, .mute_n_in, .mute_n_driven,
    .mute_n_o, .mute_n_oe_n, .zero_n_out, .auto_mute_latch_out, .out_left, .out_right,
    .fmt_sel, .force_16bit, .deemph_on, .soft_mute);
  dcm_link_checker dcm_link_checker_inst (.clk_sys(clk_sys), .nrst(nrst),
    .ctl_clk(lnk.ctl_clk), .mode_sel(lnk.mode_sel), .data_o_host(lnk.data_o_host),
    .data_oe_n_host(lnk.data_oe_n_host), .data_o_dev(lnk.data_o_dev),
    .data_oe_n_dev(lnk.data_oe_n_dev), .data_pin(lnk.data_pin),
    .latch_pin(lnk.latch_pin), .wordlen_pin(lnk.wordlen_pin));

  // 40 MHz master clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one comparison; the caller folds case equality into ok
  task automatic check(input bit ok, input string what);
    comparisons++;
    if (!ok) begin
      fail_count++;
      $display("BAD t=%0t %s", $time, what);
    end
  endtask

  // one control word through the host, waiting for it to finish
  task automatic send(input logic [15:0] w, input logic three);
    int n;
    n = 0;
    @(posedge clk_sys);
    use_3wire <= three;
    req_word  <= w;
    req       <= 1'b1;
    @(posedge clk_sys);
    req <= 1'b0;
    repeat (4) @(posedge clk_sys);
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    check(n < 4000, "host stayed busy");
    repeat (12) @(posedge clk_sys);  // registers settle a few cycles later
  endtask

  // n sample pairs, one valid pulse every other cycle
  task automatic feed(input logic [23:0] l, input logic [23:0] r, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      smp_left  <= l;
      smp_right <= r;
      smp_valid <= 1'b1;
      @(posedge clk_sys);
      smp_valid <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
  endtask

  // n frames of 2*half bit clocks, frame sync high for the first half
  task automatic frames(input int half, input int n);
    repeat (n) begin
      for (int i = 0; i < 2 * half; i++) begin
        @(posedge clk_sys);
        frame_sync_in <= (i < half);
        bit_clock_in  <= 1'b0;
        repeat (2) @(posedge clk_sys);
        bit_clock_in <= 1'b1;
        @(posedge clk_sys);
      end
    end
    repeat (8) @(posedge clk_sys);
  endtask

  // hardware straps: format from the wordlen pin with the latch pin low, de-emphasis from the released data pin
  task automatic t_hw_pins();
    sw_mode   <= 1'b0;
    strap_bit <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check(fmt_sel === dcm_pkg::DCM_FMT_RJ24, "format not rj24");
    check(deemph_on === 1'b1, "de-emphasis off with pin high");
    strap_bit <= 1'b1;
    repeat (10) @(posedge clk_sys);
    check(fmt_sel === dcm_pkg::DCM_FMT_RJ20, "format not rj20");
    strap_bit <= 1'b0;
    $display("done: hardware pins");
  endtask

  // driven mute pin: decay while low, immediate resume when high
  task automatic t_mute();
    mute_n_driven <= 1'b1;
    mute_drv      <= 1'b1;
    feed(V, V, 4);
    check(out_left === V && soft_mute === 1'b0, "no pass-through");
    mute_drv <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(soft_mute === 1'b1, "mute pin low did not mute");
    feed(V, V, 1);
    check(out_left < V && out_left > (V >> 1), "decay not gradual");
    mute_drv <= 1'b1;
    repeat (4) @(posedge clk_sys);  // pin level passes two flip-flops first
    feed(V, V, 1);
    check(out_left === V, "no immediate resume");
    $display("done: mute pin");
  endtask

  // released mute pin: zero run sets the latch, any non-zero sample clears it
  task automatic t_automute();
    mute_n_driven <= 1'b0;
    feed(24'h000000, 24'h000000, 1023);
    check(auto_mute_latch_out === 1'b0, "latch set early");
    feed(24'h000000, 24'h000000, 1);
    check(auto_mute_latch_out === 1'b1, "latch not set");
    check(zero_n_out === 1'b0, "zero output not low");
    check(mute_n_in === 1'b0 && soft_mute === 1'b1, "pin not muting");
    feed(24'h000000, 24'h000001, 1);
    check(auto_mute_latch_out === 1'b0, "latch not cleared");
    check(zero_n_out === 1'b1 && mute_n_in === 1'b1, "pin not released");
    $display("done: automute");
  endtask

  // 32 bit clocks per frame force 16-bit, 48 release it
  task automatic t_frames();
    frames(16, 4);
    check(force_16bit === 1'b1, "16-bit not detected");
    frames(24, 4);
    check(force_16bit === 1'b0, "16-bit not reverted");
    $display("done: frame detect");
  endtask

  // 2-wire writes to the dac register with both address straps
  task automatic t_two_wire();
    sw_mode <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      strap_bit <= s[0];
      repeat (20) @(posedge clk_sys);
      send({`DCM_ADDR_DAC, 9'h003}, 1'b0);
      check(nack_seen === 1'b0, "address not acknowledged");
      check(soft_mute === 1'b1 && deemph_on === 1'b1, "word not applied");
      send({`DCM_ADDR_DAC, 9'h000}, 1'b0);
      check(soft_mute === 1'b0 && deemph_on === 1'b0, "second word lost");
    end
    strap_bit <= 1'b0;
    $display("done: 2-wire");
  endtask

  // 3-wire write, sticky switch, mode toggle back to 2-wire
  task automatic t_three_wire();
    send({`DCM_ADDR_DAC, 9'h003}, 1'b1);  // first latch pulse only switches
    check(deemph_on === 1'b0 && soft_mute === 1'b0, "word taken before switch");
    send({`DCM_ADDR_DAC, 9'h002}, 1'b1);
    check(deemph_on === 1'b1 && soft_mute === 1'b0, "3-wire word lost");
    send({`DCM_ADDR_DAC, 9'h000}, 1'b0);
    check(nack_seen === 1'b1 && deemph_on === 1'b1, "2-wire still active");
    sw_mode <= 1'b0;
    repeat (40) @(posedge clk_sys);
    sw_mode <= 1'b1;
    repeat (40) @(posedge clk_sys);
    send({`DCM_ADDR_DAC, 9'h000}, 1'b0);
    check(nack_seen === 1'b0 && deemph_on === 1'b0, "2-wire not restored");
    $display("done: 3-wire");
  endtask

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("BAD t=%0t run timed out", $time);
      end_of_test();
    end
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    req = 1'b0;
    req_word = 16'h0000;
    use_3wire = 1'b0;
    sw_mode = 1'b0;
    strap_bit = 1'b0;
    smp_valid = 1'b0;
    smp_left = 24'h000000;
    smp_right = 24'h000000;
    bit_clock_in = 1'b0;
    frame_sync_in = 1'b0;
    mute_drv = 1'b1;
    mute_n_driven = 1'b1;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_hw_pins();
    t_mute();
    t_automute();
    t_frames();
    t_two_wire();
    t_three_wire();
    end_of_test();
  end
endmodule
